// file: design/codec_clock_and_source_routing.sv
// How it works
// R01: internal reset released 8 master clocks after reset; no control before that.
// R02: without pll the host supplies a master clock locked to the sample rate.
// R03: synchronous mode divides master clock by 256, 384 or 512; pll idle.
// R04: sample rates 8 to 96 kHz, ten codes, all supported.
// R05: at 96 kHz only the 256 ratio is accepted.
// R06: pll mode takes any 8 to 27 MHz clock and derives frame timing.
// R07: host programs integer and fraction before using the pll; halving comes from the measurement.
// R08: integer is floor of 196.608 MHz over input; fraction times 2048.
// R09: input halving follows measured master clock against the threshold.
// R10: one source may feed several outputs at once.
// R11: any source feeds the processor, except the processor result itself.
// R12: line bypass is its own bit, untouched by the switch.
// R13: each switch output has its own select field.
// R14: code 0x1 picks serial input, code 0x3 picks processor result.
//
// The APB register port and the register offsets are this design's own decisions.
`timescale 1ns/1ps
module codec_clock_and_source_routing
   import codec_clk_pkg::*;
(
   input  wire logic        sys_clk,
   input  wire logic        rst_b,
   input  wire logic        master_clock_in,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,
   input  wire sample_type  adc_sample,
   input  wire sample_type  serial_in_sample,
   input  wire sample_type  processor_result,
   output sample_type       serial_out_sample,
   output sample_type       dac_sample,
   output sample_type       processor_in_sample,
   output logic             frame_strobe,
   output logic             device_ready,
   output logic             line_bypass_enable
);
   // sys_clk domain state
   logic [31:0]   clk_ctrl_r;
   logic [31:0]   pll_ctrl_r;
   logic [31:0]   route_r;
   logic [31:0]   prdata_r;
   logic          pready_r;
   logic          pslverr_r;
   logic [1:0]    ready_sync_r;
   logic [1:0]    meas_sync_r;
   logic          meas_last_r;
   logic [9:0]    period_r;
   logic          halve_r;
   clk_cfg_type   cfg_hold_r;
   logic          req_tgl_r;
   logic [1:0]    ack_sync_r;
   logic [1:0]    frm_sync_r;
   logic          frm_last_r;
   logic          frame_strobe_r;
   sample_type    serial_out_r;
   sample_type    dac_r;
   sample_type    proc_in_r;
   // master clock domain state
   logic          m_rst_meta_r;
   logic          m_rst_sync_r;
   por_state_type por_state_r;
   logic [3:0]    por_cnt_r;
   logic          m_ready_r;
   logic [1:0]    m_req_sync_r;
   logic          m_ack_r;
   clk_cfg_type   m_cfg_r;
   logic [3:0]    m_meas_cnt_r;
   logic          m_meas_tgl_r;
   logic          m_half_r;
   logic [9:0]    m_div_r;
   logic [26:0]   m_acc_r;
   logic          m_frm_tgl_r;
   // apb decode
   wire setup     = psel & ~penable & ~pready_r;
   wire wr_setup  = setup & pwrite;
   wire hit_clk   = (paddr == CLK_CTRL_OFS);
   wire hit_pll   = (paddr == PLL_CTRL_OFS);
   wire hit_route = (paddr == ROUTE_OFS);
   wire hit_stat  = (paddr == STATUS_OFS);
   wire mapped    = hit_clk | hit_pll | hit_route | hit_stat;
   wire rdy       = ready_sync_r[1];
   wire wr_ok     = wr_setup & rdy & (hit_clk | hit_pll | hit_route); // R01
   wire wr_err    = wr_setup & ~(rdy & (hit_clk | hit_pll | hit_route));
   wire rd_err    = setup & ~pwrite & ~mapped;
   // field views
   wire [1:0] ratio_f = clk_ctrl_r[RATIO_LSB +: 2];
   wire [3:0] rate_f  = clk_ctrl_r[RATE_LSB +: 4];
   wire [3:0] sel_ser = route_r[SEROUT_LSB +: 4]; // R13
   wire [3:0] sel_dac = route_r[DAC_LSB +: 4]; // R13
   wire [3:0] sel_prc = route_r[PROC_LSB +: 4]; // R13
   // processor cannot take its own result
   wire [3:0] new_prc = pwdata[PROC_LSB +: 4];
   wire [3:0] prc_nxt = (new_prc == SRC_PROC) ? sel_prc : new_prc; // R11
   wire [31:0] route_nxt = {20'h00000, prc_nxt, pwdata[7:0]};
   // 96 kHz allows the 256 ratio only; ratio code 3 unused
   wire ratio_ok  = (ratio_f != 2'b11);
   wire rate_ok   = (rate_f <= FS_96K); // R04
   wire r96_ok    = (rate_f != FS_96K) | (ratio_f == RATIO_256); // R05
   wire cfg_ok    = ratio_ok & rate_ok & r96_ok;
   // configuration word bound for the master clock side
   clk_cfg_type cfg_now;
   assign cfg_now.pll_en   = clk_ctrl_r[PLL_EN_BIT];
   assign cfg_now.ratio    = cfg_ok ? ratio_f : RATIO_256;
   assign cfg_now.rate     = rate_ok ? rate_f : FS_48K;
   assign cfg_now.int_div  = pll_ctrl_r[INT_LSB +: 5]; // R07
   assign cfg_now.frac_div = pll_ctrl_r[FRAC_LSB +: 11]; // R07
   assign cfg_now.halve    = halve_r; // R09
   wire hs_idle  = (ack_sync_r[1] == req_tgl_r);
   wire cfg_send = hs_idle & (cfg_now != cfg_hold_r);
   // status word
   wire [31:0] status_w = {26'h0, ~cfg_ok, ~hs_idle, clk_ctrl_r[PLL_EN_BIT],
                           halve_r, rdy, 1'b0};
   // read mux
   wire [31:0] rd_w = hit_clk   ? clk_ctrl_r :
                      hit_pll   ? pll_ctrl_r :
                      hit_route ? route_r :
                      hit_stat  ? status_w : 32'h0;
   // apb slave: answer in the first access cycle
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         pready_r  <= 1'b0;
         pslverr_r <= 1'b0;
         prdata_r  <= 32'h0;
      end
      else
      begin
         pready_r  <= setup;
         pslverr_r <= wr_err | rd_err;
         prdata_r  <= (setup & ~pwrite) ? rd_w : 32'h0;
      end
   end
   // software registers
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         clk_ctrl_r <= CLK_CTRL_RST;
         pll_ctrl_r <= PLL_CTRL_RST;
         route_r    <= ROUTE_RST;
      end
      else
      begin
         if (wr_ok & hit_clk)
            clk_ctrl_r <= {24'h0, pwdata[7:0]};
         if (wr_ok & hit_pll)
            pll_ctrl_r <= {16'h0, pwdata[15:0]}; // R08
         if (wr_ok & hit_route)
            route_r <= route_nxt;
      end
   end
   // synchronisers into sys_clk
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         ready_sync_r <= 2'b00;
         meas_sync_r  <= 2'b00;
         ack_sync_r   <= 2'b00;
         frm_sync_r   <= 2'b00;
      end
      else
      begin
         ready_sync_r <= {ready_sync_r[0], m_ready_r}; // R01
         meas_sync_r  <= {meas_sync_r[0], m_meas_tgl_r};
         ack_sync_r   <= {ack_sync_r[0], m_ack_r};
         frm_sync_r   <= {frm_sync_r[0], m_frm_tgl_r};
      end
   end
   // master clock frequency measurement against the halving threshold
   wire meas_edge = meas_sync_r[1] ^ meas_last_r;
   wire [9:0] period_inc = (period_r == 10'h3ff) ? period_r : period_r + 10'h001;
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         meas_last_r <= 1'b0;
         period_r    <= 10'h000;
         halve_r     <= 1'b0;
      end
      else
      begin
         meas_last_r <= meas_sync_r[1];
         period_r    <= meas_edge ? 10'h000 : period_inc;
         if (meas_edge)
            halve_r <= (period_r < 10'(MEAS_THR_CYC)); // R09
      end
   end
   // configuration handshake, request side
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         cfg_hold_r <= '0;
         req_tgl_r  <= 1'b0;
      end
      else if (cfg_send)
      begin
         cfg_hold_r <= cfg_now;
         req_tgl_r  <= ~req_tgl_r;
      end
   end
   // frame event back in sys_clk
   wire frm_edge = frm_sync_r[1] ^ frm_last_r;
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         frm_last_r     <= 1'b0;
         frame_strobe_r <= 1'b0;
      end
      else
      begin
         frm_last_r     <= frm_sync_r[1];
         frame_strobe_r <= frm_edge;
      end
   end
   // source select switch; sources passed in so every change re-evaluates
   function automatic sample_type pick(input logic [3:0] code, input sample_type a, s, p);
      case (code)
         SRC_ADC:       pick = a;
         SRC_SERIAL_IN: pick = s; // R14
         SRC_PROC:      pick = p; // R14
         default:       pick = '0;
      endcase
   endfunction
   wire sample_type ser_w = pick(sel_ser, adc_sample, serial_in_sample, processor_result); // R10
   wire sample_type dac_w = pick(sel_dac, adc_sample, serial_in_sample, processor_result); // R10
   wire sample_type prc_w = pick(sel_prc, adc_sample, serial_in_sample, processor_result); // R11
   // routed outputs
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         serial_out_r <= '0;
         dac_r        <= '0;
         proc_in_r    <= '0;
      end
      else
      begin
         serial_out_r <= ser_w;
         dac_r        <= dac_w;
         proc_in_r    <= prc_w;
      end
   end
   // master clock reset: async assert, sync release
   always_ff @(posedge master_clock_in or negedge rst_b)
   begin
      if (!rst_b)
      begin
         m_rst_meta_r <= 1'b0;
         m_rst_sync_r <= 1'b0;
      end
      else
      begin
         m_rst_meta_r <= 1'b1;
         m_rst_sync_r <= m_rst_meta_r;
      end
   end
   wire m_rst_b = m_rst_sync_r;
   // internal reset release after eight master clocks
   wire por_done = (por_cnt_r == 4'(RESET_MCLKS - 1));
   always_ff @(posedge master_clock_in or negedge m_rst_b)
   begin
      if (!m_rst_b)
      begin
         por_state_r <= POR_HOLD;
         por_cnt_r   <= 4'h0;
         m_ready_r   <= 1'b0;
      end
      else
      begin
         case (por_state_r)
            POR_HOLD:
            begin
               por_cnt_r <= por_cnt_r + 4'h1;
               if (por_done) // R01
               begin
                  por_state_r <= POR_RUN;
                  m_ready_r   <= 1'b1;
               end
            end
            default:
               m_ready_r <= 1'b1;
         endcase
      end
   end
   // configuration handshake, capture side
   wire m_req = m_req_sync_r[1] ^ m_ack_r;
   always_ff @(posedge master_clock_in or negedge m_rst_b)
   begin
      if (!m_rst_b)
      begin
         m_req_sync_r <= 2'b00;
         m_ack_r      <= 1'b0;
         m_cfg_r      <= '0;
      end
      else
      begin
         m_req_sync_r <= {m_req_sync_r[0], req_tgl_r};
         if (m_req)
         begin
            m_cfg_r <= cfg_hold_r;
            m_ack_r <= ~m_ack_r;
         end
      end
   end
   // measurement tick every sixteen master clocks
   always_ff @(posedge master_clock_in or negedge m_rst_b)
   begin
      if (!m_rst_b)
      begin
         m_meas_cnt_r <= 4'h0;
         m_meas_tgl_r <= 1'b0;
      end
      else
      begin
         m_meas_cnt_r <= m_meas_cnt_r + 4'h1;
         if (m_meas_cnt_r == 4'(MEAS_MCLKS - 1))
            m_meas_tgl_r <= ~m_meas_tgl_r;
      end
   end
   // synchronous divider: ratio minus one
   wire [9:0] div_top = (m_cfg_r.ratio == RATIO_384) ? 10'h17f :
                        (m_cfg_r.ratio == RATIO_512) ? 10'h1ff : 10'h0ff; // R03
   wire div_wrap = (m_div_r == div_top);
   // pll model: fractional step per reference edge
   wire ref_tick = ~m_cfg_r.halve | m_half_r; // R09
   wire [15:0] step = {m_cfg_r.int_div, m_cfg_r.frac_div}; // R08
   wire [26:0] frame_len = {1'b0, pll_frame_cycles(m_cfg_r.rate), 11'h000};
   wire [26:0] acc_sum = m_acc_r + {11'h000, step};
   wire acc_wrap = ref_tick & (acc_sum >= frame_len) & (step != 16'h0000);
   wire [26:0] acc_nxt = acc_wrap ? acc_sum - frame_len :
                         ref_tick ? acc_sum : m_acc_r; // R06
   // frame timing in either mode; divider frozen while the pll runs
   wire frame_now = m_ready_r & (m_cfg_r.pll_en ? acc_wrap : div_wrap);
   always_ff @(posedge master_clock_in or negedge m_rst_b)
   begin
      if (!m_rst_b)
      begin
         m_half_r    <= 1'b0;
         m_div_r     <= 10'h000;
         m_acc_r     <= 27'h0;
         m_frm_tgl_r <= 1'b0;
      end
      else
      begin
         m_half_r <= ~m_half_r;
         m_div_r  <= (m_cfg_r.pll_en | div_wrap) ? 10'h000 : m_div_r + 10'h001; // R03
         m_acc_r  <= m_cfg_r.pll_en ? acc_nxt : 27'h0; // R06
         if (frame_now)
            m_frm_tgl_r <= ~m_frm_tgl_r;
      end
   end
   // outputs
   assign prdata              = prdata_r;
   assign pready              = pready_r;
   assign pslverr             = pslverr_r;
   assign serial_out_sample   = serial_out_r;
   assign dac_sample          = dac_r;
   assign processor_in_sample = proc_in_r;
   assign frame_strobe        = frame_strobe_r;
   assign device_ready        = ready_sync_r[1];
   assign line_bypass_enable  = clk_ctrl_r[BYPASS_BIT]; // R12
endmodule // codec_clock_and_source_routing

// file: design/codec_clk_pkg.sv
package codec_clk_pkg;
   // register byte offsets
   localparam logic [7:0] CLK_CTRL_OFS = 8'h00;
   localparam logic [7:0] PLL_CTRL_OFS = 8'h04;
   localparam logic [7:0] ROUTE_OFS    = 8'h08;
   localparam logic [7:0] STATUS_OFS   = 8'h0c;
   // clock control fields
   localparam int PLL_EN_BIT = 0;
   localparam int RATIO_LSB  = 1;
   localparam int RATE_LSB   = 3;
   localparam int BYPASS_BIT = 7;
   // pll control fields
   localparam int FRAC_LSB = 0;
   localparam int INT_LSB  = 11;
   // routing fields, one per switch output
   localparam int SEROUT_LSB = 0;
   localparam int DAC_LSB    = 4;
   localparam int PROC_LSB   = 8;
   // source codes
   localparam logic [3:0] SRC_ADC       = 4'h0;
   localparam logic [3:0] SRC_SERIAL_IN = 4'h1;
   localparam logic [3:0] SRC_PROC      = 4'h3;
   // reset values
   localparam logic [31:0] CLK_CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] PLL_CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] ROUTE_RST    = 32'h0000_0010;
   // timing
   localparam int RESET_MCLKS   = 8;
   localparam int SYS_CLK_MHZ   = 200;
   localparam int HALVE_MHZ     = 17;
   localparam int MEAS_MCLKS    = 16;
   localparam int MEAS_THR_CYC  = SYS_CLK_MHZ * MEAS_MCLKS / HALVE_MHZ;
   localparam int PLL_FRAC_BITS = 11;
   typedef enum logic [1:0] {
      RATIO_256 = 2'b00,
      RATIO_384 = 2'b01,
      RATIO_512 = 2'b10
   } ratio_type;
   typedef enum logic [3:0] {
      FS_8K = 4'h0, FS_11K = 4'h1, FS_12K = 4'h2, FS_16K = 4'h3,
      FS_22K = 4'h4, FS_24K = 4'h5, FS_32K = 4'h6, FS_44K = 4'h7,
      FS_48K = 4'h8, FS_96K = 4'h9
   } rate_type;
   typedef enum logic {
      POR_HOLD = 1'b0,
      POR_RUN  = 1'b1
   } por_state_type;
   typedef struct packed {
      logic [23:0] left;
      logic [23:0] right;
   } sample_type;
   typedef struct packed {
      logic        pll_en;
      logic [1:0]  ratio;
      logic [3:0]  rate;
      logic [4:0]  int_div;
      logic [10:0] frac_div;
      logic        halve;
   } clk_cfg_type;
   // pll output cycles per frame at the 196.608 MHz target
   function automatic logic [14:0] pll_frame_cycles(input logic [3:0] r);
      case (r)
         FS_8K:   pll_frame_cycles = 15'h6000;
         FS_11K:  pll_frame_cycles = 15'h45a9;
         FS_12K:  pll_frame_cycles = 15'h4000;
         FS_16K:  pll_frame_cycles = 15'h3000;
         FS_22K:  pll_frame_cycles = 15'h22d4;
         FS_24K:  pll_frame_cycles = 15'h2000;
         FS_32K:  pll_frame_cycles = 15'h1800;
         FS_44K:  pll_frame_cycles = 15'h116a;
         FS_48K:  pll_frame_cycles = 15'h1000;
         default: pll_frame_cycles = 15'h0800;
      endcase
   endfunction
endpackage

// file: dv/codec_clock_and_source_routing_monitor.sv
`timescale 1ns/1ps
module route_clock_monitor
   import codec_clk_pkg::*;
(
   input wire logic        sys_clk,
   input wire logic        rst_b,
   input wire logic        master_clock_in,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire sample_type  adc_sample,
   input wire sample_type  serial_in_sample,
   input wire sample_type  processor_result,
   input wire sample_type  serial_out_sample,
   input wire sample_type  dac_sample,
   input wire logic        frame_strobe,
   input wire logic        device_ready,
   input wire logic        line_bypass_enable
);
   logic [3:0] dac_sel_r;
   logic [3:0] ser_sel_r;
   logic [3:0] mclk_cnt_r;
   wire        route_wr = pready && pwrite && !pslverr && paddr == ROUTE_OFS;
   // shadow of accepted routing selects
   always_ff @(posedge sys_clk or negedge rst_b)
      if (!rst_b)
      begin
         dac_sel_r <= ROUTE_RST[7:4];
         ser_sel_r <= ROUTE_RST[3:0];
      end
      else if (route_wr)
      begin
         dac_sel_r <= pwdata[DAC_LSB +: 4];
         ser_sel_r <= pwdata[SEROUT_LSB +: 4];
      end
   // master clocks seen since reset, saturating
   always_ff @(posedge master_clock_in or negedge rst_b)
      if (!rst_b)
         mclk_cnt_r <= 4'h0;
      else if (mclk_cnt_r != 4'hf)
         mclk_cnt_r <= mclk_cnt_r + 4'h1;
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rst_b);
   // bus answer and release relations
   ack_next_a: assert property (psel && !penable && !pready |=> pready)
      else $error("no pready after setup");
   ack_pulse_a: assert property (pready |=> !pready)
      else $error("pready longer than one cycle");
   early_write_a: assert property (pready && pwrite && !$past(device_ready) |-> pslverr)
      else $error("write before release accepted");
   ready_delay_a: assert property (device_ready |-> mclk_cnt_r >= RESET_MCLKS + 2)
      else $error("release too early");
   frame_gate_a: assert property (frame_strobe |-> device_ready)
      else $error("frame before release");
   // dac and serial out follow the selected source; bypass holds across routing writes
   // first edge after reset still shows the reset value of the outputs
   dac_serial_a: assert property ($past(rst_b) && dac_sel_r == SRC_SERIAL_IN
      |-> dac_sample == $past(serial_in_sample))
      else $error("dac not fed by serial input");
   dac_proc_a: assert property ($past(rst_b) && dac_sel_r == SRC_PROC
      |-> dac_sample == $past(processor_result))
      else $error("dac not fed by processor");
   serout_adc_a: assert property ($past(rst_b) && ser_sel_r == SRC_ADC
      |-> serial_out_sample == $past(adc_sample))
      else $error("serial out not fed by adc");
   bypass_keep_a: assert property (route_wr |=> $stable(line_bypass_enable))
      else $error("bypass moved by routing write");
endmodule // route_clock_monitor

bind codec_clock_and_source_routing route_clock_monitor mon_u (
   .sys_clk, .rst_b, .master_clock_in, .psel, .penable, .pwrite, .paddr, .pwdata, .pready, .pslverr,
   .adc_sample, .serial_in_sample, .processor_result, .serial_out_sample, .dac_sample,
   .frame_strobe, .device_ready, .line_bypass_enable
);

// file: dv/audio_host_model.sv
`timescale 1ns/1ps
module audio_host_model
   import codec_clk_pkg::*;
(
   input wire logic  sys_clk,
   input wire logic  rst_b,
   output logic      master_clock_in,
   output sample_type adc_sample,
   output sample_type serial_in_sample,
   output sample_type processor_result
);
   logic [23:0] ramp_r;
   // free running master clock, phase unrelated to sys_clk
   initial
   begin
      master_clock_in = 1'b0;
      #1.1;
      forever #7.5 master_clock_in = ~master_clock_in;
   end
   // ramp moving every cycle so stale data shows
   always @(posedge sys_clk or negedge rst_b)
      if (!rst_b)
         ramp_r <= 24'h0;
      else
         ramp_r <= ramp_r + 24'h1;
   // distinct pattern per source
   assign adc_sample       = {ramp_r, ~ramp_r};
   assign serial_in_sample = {ramp_r ^ 24'h5a5a5a, ramp_r};
   assign processor_result = {~ramp_r, ramp_r ^ 24'h3c3c3c};
endmodule // audio_host_model

// file: dv/tb_codec_clock_and_source_routing.sv
`timescale 1ns/1ps
module tb_codec_clock_and_source_routing
   import codec_clk_pkg::*;
;
   logic       sys_clk, rst_b, psel, penable, pwrite, pready, pslverr, err;
   logic       master_clock_in, frame_strobe, device_ready, line_bypass_enable;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   sample_type adc_sample, serial_in_sample, processor_result;
   sample_type serial_out_sample, dac_sample, processor_in_sample, prev_ser, prev_adc, prev_proc;
   int         failures, n_tests, mcnt;
   codec_clock_and_source_routing dut_u (.sys_clk, .rst_b, .master_clock_in, .psel, .penable, .pwrite,
      .paddr, .pwdata, .prdata, .pready, .pslverr, .adc_sample, .serial_in_sample, .processor_result,
      .serial_out_sample, .dac_sample, .processor_in_sample, .frame_strobe, .device_ready,
      .line_bypass_enable);
   audio_host_model host_u (.sys_clk, .rst_b, .master_clock_in, .adc_sample, .serial_in_sample,
      .processor_result);
   // system clock
   initial
   begin
      sys_clk = 1'b0;
      forever #2.5 sys_clk = ~sys_clk;
   end
   // master clock count and source history
   always @(posedge master_clock_in) mcnt <= mcnt + 1;
   always @(posedge sys_clk)
   begin
      prev_ser <= serial_in_sample;
      prev_adc <= adc_sample;
      prev_proc <= processor_result;
   end
   task end_of_test;
      $display("comparisons %0d mismatches %0d", n_tests, failures);
      if (failures == 0 && n_tests > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   task chk(input logic [47:0] got, input logic [47:0] exp);
      n_tests++;
      if (got !== exp)
      begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // bounded wait on pready, frame_strobe or device_ready
   task wait_for(input int which);
      int n;
      n = 0;
      do
      begin
         @(posedge sys_clk);
         n++;
      end
      while ((which == 0 ? pready : which == 1 ? frame_strobe : device_ready) !== 1'b1 && n < 4000);
      if (n >= 4000)
      begin
         failures++;
         end_of_test();
      end
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge sys_clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge sys_clk);
      penable <= 1'b1;
      wait_for(0);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [31:0] d, input logic e);
      apb(1'b1, a, d);
      chk(err, e);
   endtask
   task rdchk(input logic [7:0] a, input logic [31:0] d, input logic e);
      apb(1'b0, a, 32'h0);
      chk(rd, d);
      chk(err, e);
   endtask
   // master clocks between two settled frames
   task meas(input int exp, input int tol);
      int m0;
      wait_for(1);
      wait_for(1);
      m0 = mcnt;
      wait_for(1);
      chk(48'(mcnt - m0 >= exp - tol && mcnt - m0 <= exp + tol), 48'h1);
   endtask
   task t_early;
      wr(CLK_CTRL_OFS, 32'h0000_0080, 1'b1);
      wait_for(2);
      rdchk(CLK_CTRL_OFS, CLK_CTRL_RST, 1'b0);
      rdchk(PLL_CTRL_OFS, PLL_CTRL_RST, 1'b0);
      rdchk(ROUTE_OFS, ROUTE_RST, 1'b0);
      rdchk(8'h10, 32'h0, 1'b1);
      wr(STATUS_OFS, 32'h0, 1'b1);
      $display("early access test done");
   endtask
   task t_rates;
      for (int r = 0; r < 11; r++)
         for (int q = 0; q < 4; q++)
         begin
            wr(CLK_CTRL_OFS, 32'((r << RATE_LSB) | (q << RATIO_LSB)), 1'b0);
            apb(1'b0, STATUS_OFS, 32'h0);
            chk(rd[5], r > 9 || q == 3 || (r == 9 && q != 0));
            chk(rd[3], 1'b0);
         end
      $display("rate table test done");
   endtask
   task t_route;
      wr(CLK_CTRL_OFS, 32'h0000_00c0, 1'b0);
      wr(ROUTE_OFS, 32'h0000_0131, 1'b0);
      @(posedge sys_clk);
      #1;
      chk(serial_out_sample, prev_ser);
      chk(processor_in_sample, prev_ser);
      chk(dac_sample, prev_proc);
      chk(line_bypass_enable, 1'b1);
      wr(ROUTE_OFS, 32'h0000_0302, 1'b0);
      rdchk(ROUTE_OFS, 32'h0000_0102, 1'b0);
      @(posedge sys_clk);
      #1;
      chk(dac_sample, prev_adc);
      chk(serial_out_sample, 48'h0);
      chk(processor_in_sample, prev_ser);
      chk(line_bypass_enable, 1'b1);
      $display("routing test done");
   endtask
   task t_frames;
      for (int q = 0; q < 3; q++)
      begin
         wr(CLK_CTRL_OFS, 32'(8'h40 | (q << RATIO_LSB)), 1'b0);
         meas(256 + q * 128, 2);
      end
      $display("sync frame test done");
   endtask
   task t_pll;
      int ref_khz;
      int step;
      ref_khz = 1000000 / 15 / 2;
      step = 196608 * 2048 / ref_khz;
      wr(PLL_CTRL_OFS, 32'(((step / 2048) << INT_LSB) | ((step % 2048) << FRAC_LSB)), 1'b0);
      wr(CLK_CTRL_OFS, 32'h0000_0049, 1'b0);
      apb(1'b0, STATUS_OFS, 32'h0);
      chk(rd[3:2], 2'b11);
      meas(2 * 2048 * 2048 / step, 4);
      $display("pll frame test done");
   endtask
   // reset, then the scenarios in order
   initial
   begin
      rst_b = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h0;
      pwdata = 32'h0;
      failures = 0;
      n_tests = 0;
      repeat (16) @(posedge sys_clk);
      rst_b <= 1'b1;
      t_early();
      t_rates();
      t_route();
      t_frames();
      t_pll();
      end_of_test();
   end
endmodule // tb_codec_clock_and_source_routing
